// ==== hdl/cls_core_ctrl.sv ====
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cls_core_ctrl
  import cls_pkg::*;
#(
  parameter int NUM = CLS_NUM_CORES
) (
  input  wire logic          clk_sys,     // system clock
  input  wire logic          rst,         // async reset, high
  input  wire logic          ce,          // clock enable
  input  wire logic          start_req,   // start operation pulse
  input  wire logic [8:0]    start_dest,  // destination value
  input  wire logic [31:0]   start_src,   // source operand
  input  wire logic          start_wc,    // carry_result_request
  input  wire logic          start_reg,   // destination is a register
  input  wire logic          start_queued,// queue_value_prefix preceded
  input  wire logic [31:0]   start_qval,  // queued value
  input  wire logic          stop_req,    // stop operation pulse
  input  wire logic [8:0]    stop_dest,   // stop operand
  input  wire logic          mem_rvalid,  // shared memory data valid
  input  wire logic [31:0]   mem_rdata,   // shared memory data
  input  wire logic [3:0]    reg_addr,    // register byte address
  input  wire logic [31:0]   reg_wdata,   // register write data
  input  wire logic          reg_wr,      // register write strobe
  input  wire logic          reg_rd,      // register read strobe
  output logic [31:0]        reg_rdata,   // read data, one cycle later
  output logic               busy,        // start not accepted while high
  output logic               done,        // start finished pulse
  output logic               carry,       // result carry
  output logic               res_we,      // write result to dest register
  output logic [31:0]        res_val,     // result value
  output logic [NUM-1:0]     running,     // running cores
  output logic [NUM-1:0]     core_launch, // launch pulse per core
  output logic [NUM-1:0]     core_halt,   // stop pulse per core
  output logic [19:0]        launch_pc,   // starting code address
  output logic [31:0]        code_pointer,// code pointer value
  output logic [31:0]        param_ptr,   // parameter pointer value
  output logic               mem_rd,      // shared memory read pulse
  output logic [19:0]        mem_addr,    // shared memory address
  output logic               loc_we,      // local memory write
  output logic [2:0]         loc_core,    // local memory core
  output logic [8:0]         loc_addr,    // local memory address
  output logic [31:0]        loc_data     // local memory data
);

  typedef struct packed {
    cls_state_e  state;
    logic [2:0]  target;
    logic        e_bit;
    logic        wc;
    logic        to_reg;
    logic        queued;
    logic [31:0] src;
    logic [31:0] qval;
    logic [8:0]  idx;
    logic        busy;
    logic [NUM-1:0] run;
    logic [NUM-1:0] launch;
    logic [NUM-1:0] halt;
    logic [19:0] pc;
    logic [31:0] cptr;
    logic [31:0] pptr;
    logic        done;
    logic        carry;
    logic        res_we;
    logic [31:0] res_val;
    logic        mem_rd;
    logic [19:0] mem_addr;
    logic        loc_we;
    logic [8:0]  loc_addr;
    logic [31:0] loc_data;
    logic [7:0]  mask;
    logic [3:0]  last_id;
    logic        last_fail;
    logic [31:0] rdata;
  } cls_state_s;

  cls_state_s r;
  cls_state_s next_r;

  logic          one_ok;
  logic [2:0]    one_id;
  logic          pair_ok;
  logic [2:0]    pair_id;
  logic          take;
  logic          ld_n;
  logic          free_sel;
  logic [2:0]    vfield;

  cls_free_pick #(.NUM(NUM)) u_pick (
    .avail   (~r.run & r.mask[NUM-1:0]),
    .one_ok  (one_ok),
    .one_id  (one_id),
    .pair_ok (pair_ok),
    .pair_id (pair_id)
  );

  assign take     = start_req && !r.busy;
  assign ld_n     = start_dest[CLS_DST_LOAD];
  assign free_sel = start_dest[CLS_DST_FREE];
  assign vfield   = start_dest[2:0];

  always_comb begin
    logic       ok;
    logic [2:0] tgt;
    ok     = 1'b0;
    tgt    = '0;
    next_r = r;
    next_r.launch = '0;
    next_r.halt   = '0;
    next_r.done   = 1'b0;
    next_r.res_we = 1'b0;
    next_r.mem_rd = 1'b0;
    next_r.loc_we = 1'b0;
    next_r.rdata  = '0;
    // ---------------------------------------------------------------
    // stop operation
    // ---------------------------------------------------------------
    // launch below overrides a stop of the same core
    if (stop_req) begin
      next_r.run[stop_dest[2:0]]  = 1'b0;
      next_r.halt[stop_dest[2:0]] = 1'b1;
    end
    // ---------------------------------------------------------------
    // start sequencer
    // ---------------------------------------------------------------
    case (r.state)
      CLS_IDLE: begin
        if (take) begin
          if (!free_sel) begin
            ok  = 1'b1;
            tgt = vfield;
          end else if (vfield == CLS_V_ONE) begin
            ok  = one_ok;
            tgt = one_id;
          end else if (vfield == CLS_V_PAIR) begin
            ok  = pair_ok;
            tgt = pair_id;
          end
          next_r.target = tgt;
          next_r.e_bit  = ld_n;
          next_r.wc     = start_wc;
          next_r.to_reg = start_reg;
          next_r.queued = start_queued;
          next_r.src    = start_src;
          next_r.qval   = start_qval;
          next_r.idx    = CLS_COPY_FIRST;
          if (!ok) begin
            next_r.done      = 1'b1;
            next_r.carry     = start_wc;
            next_r.res_we    = start_wc && start_reg;
            next_r.res_val   = CLS_FAIL_ID;
            next_r.last_fail = 1'b1;
            next_r.last_id   = CLS_FAIL_ID[3:0];
          end else begin
            next_r.busy = 1'b1;
            // running cores restart; loaded cores halt during copy
            next_r.run[tgt] = 1'b0;
            next_r.state = ld_n ? CLS_LAUNCH : CLS_COPY_RD;
          end
        end
      end
      CLS_COPY_RD: begin
        next_r.mem_rd   = 1'b1;
        next_r.mem_addr = r.src[19:0] + {9'h000, r.idx, 2'b00};
        next_r.state    = CLS_COPY_WAIT;
      end
      CLS_COPY_WAIT: begin
        if (mem_rvalid) begin
          next_r.loc_we   = 1'b1;
          next_r.loc_addr = r.idx;
          next_r.loc_data = mem_rdata;
          next_r.idx      = r.idx + 9'h001;
          next_r.state    = (r.idx == CLS_COPY_LAST) ? CLS_LAUNCH
                                                     : CLS_COPY_RD;
        end
      end
      CLS_LAUNCH: begin
        next_r.launch[r.target] = 1'b1;
        next_r.run[r.target]    = 1'b1;
        next_r.pc   = r.e_bit ? r.src[19:0]
                              : CLS_LOC_START;
        next_r.cptr = r.src;
        next_r.pptr = r.queued ? r.qval : '0;
        next_r.done      = 1'b1;
        next_r.carry     = 1'b0;
        next_r.res_we    = r.wc && r.to_reg;
        next_r.res_val   = {29'h0, r.target};
        next_r.last_fail = 1'b0;
        next_r.last_id   = {1'b0, r.target};
        next_r.busy      = 1'b0;
        next_r.state     = CLS_IDLE;
      end
      default: begin
        next_r.state = CLS_IDLE;
        next_r.busy  = 1'b0;
      end
    endcase
    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    if (reg_wr && reg_addr == CLS_REG_MASK) begin
      next_r.mask = reg_wdata[7:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        CLS_REG_RUN:  next_r.rdata = {23'h0, r.busy, 8'(r.run)};
        CLS_REG_MASK: next_r.rdata = {24'h0, r.mask};
        CLS_REG_LAST: next_r.rdata = {27'h0, r.last_fail, r.last_id};
        default:      next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r       <= '0;
      r.state <= CLS_IDLE;
      r.mask  <= CLS_MASK_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign reg_rdata    = r.rdata;
  assign busy         = r.busy;
  assign done         = r.done;
  assign carry        = r.carry;
  assign res_we       = r.res_we;
  assign res_val      = r.res_val;
  assign running      = r.run;
  assign core_launch  = r.launch;
  assign core_halt    = r.halt;
  assign launch_pc    = r.pc;
  assign code_pointer = r.cptr;
  assign param_ptr    = r.pptr;
  assign mem_rd       = r.mem_rd;
  assign mem_addr     = r.mem_addr;
  assign loc_we       = r.loc_we;
  assign loc_core     = r.target;
  assign loc_addr     = r.loc_addr;
  assign loc_data     = r.loc_data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_fail_value: assert property (
    (r.res_we && r.carry) |-> r.res_val == CLS_FAIL_ID)
    else $error("failure result is not F");

  a_launch_ok: assert property (
    (|r.launch) |-> (r.done && !r.carry && $onehot(r.launch)
      && (r.run & r.launch) == r.launch))
    else $error("launch without success report");

  a_copy_range: assert property (
    r.loc_we |-> (r.loc_addr <= CLS_COPY_LAST && !r.run[r.target]))
    else $error("local copy outside range or while running");

  a_copy_pc: assert property (
    ((|r.launch) && !r.e_bit) |-> (r.pc == CLS_LOC_START
      && $past(r.idx) == CLS_COPY_LAST + 9'h001))
    else $error("loaded core not started at zero after full copy");

  a_noload_ptr: assert property (
    ((|r.launch) && r.e_bit) |-> (r.pc == r.src[19:0]
      && r.cptr == r.src))
    else $error("no-load launch address or code pointer wrong");

  a_auto_lowest: assert property (
    (ce && take && free_sel && vfield == CLS_V_ONE && ld_n && one_ok
      && !stop_req)
    |=> ##1 ((|r.launch)
      && ($past(~r.run & r.mask[NUM-1:0], 2) & r.launch) == r.launch
      && ($past(~r.run & r.mask[NUM-1:0], 2) & (r.launch - 1'b1)) == '0))
    else $error("automatic pick not the lowest free core");

  a_stop_halts: assert property (
    (ce && stop_req && !(r.state == CLS_LAUNCH))
    |=> !r.run[$past(stop_dest[2:0])] && r.halt[$past(stop_dest[2:0])])
    else $error("stopped core still running");

  a_param_ptr: assert property (
    (|r.launch) |-> r.pptr == (r.queued ? r.qval : 32'h0))
    else $error("parameter pointer wrong at launch");

  a_restart: assert property (
    (ce && take && !free_sel && ld_n && r.run[vfield])
    |=> ##1 r.launch[$past(vfield, 2)])
    else $error("running core not restarted");

  // ---------------------------------------------------------------
  // decode, copy and result checks
  // ---------------------------------------------------------------
  a_pair_even: assert property (
    (ce && take && free_sel && vfield == CLS_V_PAIR && ld_n && pair_ok
      && !stop_req)
    |=> ##1 ((r.launch & {(NUM/2){2'b01}}) == r.launch && (|r.launch)
      && ($past(~r.run & r.mask[NUM-1:0], 2) & (r.launch << 1)) != '0))
    else $error("pair launch not on an even core with idle partner");

  a_fixed_target: assert property (
    (ce && take && !start_dest[CLS_DST_FREE] && start_dest[CLS_DST_LOAD])
    |=> ##1 r.launch[$past(start_dest[2:0], 2)])
    else $error("explicit target not launched");

  a_bad_field: assert property (
    (ce && take && free_sel && vfield != CLS_V_ONE && vfield != CLS_V_PAIR)
    |=> (r.done && !(|r.launch) && r.carry == $past(start_wc)))
    else $error("invalid free field not reported as failure");

  a_auto_fail: assert property (
    (ce && take && free_sel && vfield == CLS_V_ONE
      && (~r.run & r.mask[NUM-1:0]) == '0)
    |=> (r.done && !(|r.launch) && r.res_val == CLS_FAIL_ID))
    else $error("automatic pick without a free core did not fail");

  a_success_id: assert property (
    (r.res_we && !r.carry)
    |-> (r.res_val[31:CLS_ID_W] == '0 && r.launch[r.res_val[2:0]]))
    else $error("success result does not name the launched core");

  a_wc_off: assert property (
    (r.done && !r.wc) |-> (!r.res_we && !r.carry))
    else $error("result reported without a request");

  a_load_first: assert property (
    (ce && take && !free_sel && !ld_n)
    |=> ##1 (r.mem_rd && r.mem_addr == $past(start_src[19:0], 2)))
    else $error("copy does not start at the source address");

  a_copy_next: assert property (
    (ce && r.loc_we) |=> (r.mem_rd || (|r.launch)))
    else $error("copy stalled after a local write");

  a_halt_dormant: assert property (
    (r.halt & r.run & ~r.launch) == '0)
    else $error("halted core still marked running");

  a_target_idle: assert property (
    r.busy |-> !r.run[r.target])
    else $error("target runs while its start is pending");

endmodule : cls_core_ctrl

// ==== hdl/cls_pkg.sv ====
//
// Behaviour
// - with result requested, carry set on failed launch, else cleared
// - result register gets F on failure, else launched or lower pair id
// - destination decodes as load bit, free bit, ignored bit, 3-bit target
// - load mode copies shared memory into local 000..1F7, runs from 000
// - no-load mode skips copy and runs at the source address
// - free bit clear: target field is the explicit core id 0..7
// - free bit set: field 000 any free core, 001 free even/odd pair
// - automatic selection picks only cores that are not running
// - low 20 source bits are the copy address in load mode, else the target's starting code address
// - full 32-bit source goes into the target's code pointer
// - stopped cores keep local memory; no-load restart below 400 resumes
// - stop makes the core named by operand bits 2:0 dormant
// - naming a running core restarts it with the new parameters
package cls_pkg;

  localparam int          CLS_NUM_CORES  = 8;
  localparam int          CLS_ID_W       = 3;
  localparam int          CLS_ADDR_W     = 20;
  localparam int          CLS_LOC_W      = 9;
  // ---------------------------------------------------------------
  // destination field layout
  // ---------------------------------------------------------------
  localparam int          CLS_DST_LOAD   = 5;
  localparam int          CLS_DST_FREE   = 4;
  localparam logic [2:0]  CLS_V_ONE      = 3'h0;
  localparam logic [2:0]  CLS_V_PAIR     = 3'h1;
  // ---------------------------------------------------------------
  // copy and launch values
  // ---------------------------------------------------------------
  localparam logic [8:0]  CLS_COPY_FIRST = 9'h000;
  localparam logic [8:0]  CLS_COPY_LAST  = 9'h1F7;
  localparam logic [19:0] CLS_LOC_START  = 20'h00000;
  localparam logic [31:0] CLS_FAIL_ID    = 32'h0000000F;
  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  CLS_REG_RUN    = 4'h0;
  localparam logic [3:0]  CLS_REG_MASK   = 4'h4;
  localparam logic [3:0]  CLS_REG_LAST   = 4'h8;
  localparam logic [7:0]  CLS_MASK_RST   = 8'hFF;

  typedef enum logic [1:0] {
    CLS_IDLE      = 2'h0,
    CLS_COPY_RD   = 2'h1,
    CLS_COPY_WAIT = 2'h3,
    CLS_LAUNCH    = 2'h2
  } cls_state_e;

endpackage : cls_pkg

// ==== hdl/cls_free_pick.sv ====
`timescale 1ns/1ps
module cls_free_pick
  import cls_pkg::*;
#(
  parameter int NUM = CLS_NUM_CORES
) (
  input  wire logic [NUM-1:0]      avail,   // idle and allowed cores
  output logic                     one_ok,  // a free core exists
  output logic [CLS_ID_W-1:0]      one_id,  // lowest free core
  output logic                     pair_ok, // a free even/odd pair exists
  output logic [CLS_ID_W-1:0]      pair_id  // even core of lowest pair
);

  always_comb begin
    one_ok  = 1'b0;
    one_id  = '0;
    pair_ok = 1'b0;
    pair_id = '0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (avail[i]) begin
        one_ok = 1'b1;
        one_id = CLS_ID_W'(i);
      end
    end
    for (int i = NUM - 2; i >= 0; i -= 2) begin
      if (avail[i] && avail[i+1]) begin
        pair_ok = 1'b1;
        pair_id = CLS_ID_W'(i);
      end
    end
  end

endmodule : cls_free_pick

// ==== verification/cls_mem_model.sv ====
`timescale 1ns/1ps
module cls_mem_model (
  input  wire logic        clk_sys,    // system clock
  input  wire logic        rst,        // async reset, high
  input  wire logic [3:0]  lat,        // answer delay, 1..15 cycles
  input  wire logic        mem_rd,     // read pulse
  input  wire logic [19:0] mem_addr,   // read address
  output logic             mem_rvalid, // data valid pulse
  output logic [31:0]      mem_rdata   // read data
);
  logic [19:0] a;
  logic [3:0]  cnt;
  // ---------------------------------------------------------------
  // each word holds its own address, marked; stale data is inverted
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a          <= 20'h00000;
      cnt        <= 4'h0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h00000000;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_rd) begin
        a   <= mem_addr;
        cnt <= lat;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          mem_rvalid <= 1'b1;
          mem_rdata  <= {12'h5A0, a};
        end
      end
    end
  end
endmodule : cls_mem_model

// ==== verification/test_core_launch_stop_control.sv ====
`timescale 1ns/1ps
module test_core_launch_stop_control;
  import cls_pkg::*;
  typedef struct packed {
    logic [8:0]  d;
    logic [31:0] s;
    logic        q;
    logic [31:0] id;
  } cls_row_s;
  localparam logic [31:0] QV = 32'hC0FFEE11;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        start_req = 1'b0;
  logic [8:0]  start_dest = 9'h000;
  logic [31:0] start_src = 32'h00000000;
  logic        start_wc = 1'b1;
  logic        start_reg = 1'b0;
  logic        start_queued = 1'b0;
  logic [31:0] start_qval = QV;
  logic        stop_req = 1'b0;
  logic [8:0]  stop_dest = 9'h000;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  lat = 4'h1;
  logic        mem_rvalid, busy, done, carry, res_we, mem_rd, loc_we;
  logic [31:0] mem_rdata, reg_rdata, res_val, code_pointer, param_ptr;
  logic [31:0] loc_data;
  logic [7:0]  running, core_launch, core_halt, run_c1;
  logic [19:0] launch_pc, mem_addr, cbase;
  logic [8:0]  loc_addr, last_a;
  logic [2:0]  loc_core;
  int          err_count = 0;
  int          samples_checked = 0;
  int          loc_n = 0;
  cls_row_s    rows [6];

  cls_core_ctrl DUT (
    .clk_sys, .rst, .ce, .start_req, .start_dest, .start_src, .start_wc,
    .start_reg, .start_queued, .start_qval, .stop_req, .stop_dest,
    .mem_rvalid, .mem_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .busy, .done, .carry, .res_we, .res_val, .running,
    .core_launch, .core_halt, .launch_pc, .code_pointer, .param_ptr,
    .mem_rd, .mem_addr, .loc_we, .loc_core, .loc_addr, .loc_data
  );
  cls_mem_model MEM (
    .clk_sys, .rst, .lat, .mem_rd, .mem_addr, .mem_rvalid, .mem_rdata
  );

  always #4 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task start(input logic [8:0] d, input logic [31:0] s, input logic rg,
             input logic q);
    @(posedge clk_sys);
    start_req    <= 1'b1;
    start_dest   <= d;
    start_src    <= s;
    start_reg    <= rg;
    start_queued <= q;
    @(posedge clk_sys);
    start_req <= 1'b0;
    @(negedge clk_sys);
    run_c1 = running;
    for (int n = 0; n < 9000 && done !== 1'b1; n++) @(negedge clk_sys);
  endtask : start

  task chk_res(input logic [31:0] id, input logic [19:0] pc,
               input logic [31:0] cp, input logic [31:0] pp);
    logic f;
    f = (id === CLS_FAIL_ID);
    chk(32'(carry), 32'(f));
    chk(res_val, id);
    chk(32'(res_we), 32'(start_reg));
    chk(32'(core_launch), f ? 32'h0 : 32'h1 << id[2:0]);
    if (!f) begin
      chk(32'(launch_pc), 32'(pc));
      chk(code_pointer, cp);
      chk(param_ptr, pp);
    end
  endtask : chk_res

  task reg_op(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    if (!w)
      chk(reg_rdata, v);
  endtask : reg_op

  // ---------------------------------------------------------------
  // local memory writes carry the shared word of each index
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (loc_we === 1'b1) begin
      chk(loc_data, {12'h5A0, cbase + {9'h0, loc_addr, 2'b00}});
      chk(32'(loc_core), 32'h7);
      last_a = loc_addr;
      loc_n++;
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end

  initial begin
    rows[0] = '{9'h025, 32'hABC12345, 1'b0, 32'h5};
    rows[1] = '{9'h030, 32'h00000400, 1'b1, 32'h0};
    rows[2] = '{9'h031, 32'h00000800, 1'b0, 32'h2};
    rows[3] = '{9'h02E, 32'h000FFFFC, 1'b1, 32'h6};
    rows[4] = '{9'h032, 32'h00000400, 1'b0, CLS_FAIL_ID};
    rows[5] = '{9'h030, 32'h00000500, 1'b0, 32'h1};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(running), 32'h0);
    reg_op(1'b1, CLS_REG_RUN, 32'hFFFFFFFF);
    reg_op(1'b0, CLS_REG_RUN, 32'h0);
    reg_op(1'b0, CLS_REG_MASK, 32'hFF);
    reg_op(1'b0, 4'hC, 32'h0);
    // no-load launches: fixed, free, pair, ignored bit, bad field
    for (int i = 0; i < 6; i++) begin
      start(rows[i].d, rows[i].s, 1'b1, rows[i].q);
      chk_res(rows[i].id, rows[i].s[19:0], rows[i].s,
              rows[i].q ? QV : 32'h0);
    end
    // stop by low operand bits, then resume resident code
    @(posedge clk_sys);
    stop_req  <= 1'b1;
    stop_dest <= 9'h1F5;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    @(negedge clk_sys);
    chk(32'(core_halt), 32'h20);
    chk(32'(running[5]), 32'h0);
    start(9'h025, 32'h00000123, 1'b1, 1'b0);
    chk_res(32'h5, 20'h00123, 32'h00000123, 32'h0);
    chk(32'(loc_n), 32'h0);
    start(9'h025, 32'h00000456, 1'b1, 1'b1);
    chk(32'(run_c1[5]), 32'h0);
    chk_res(32'h5, 20'h00456, 32'h00000456, QV);
    // no core allowed: automatic pick fails, no result write
    reg_op(1'b1, CLS_REG_MASK, 32'h0);
    reg_op(1'b0, CLS_REG_MASK, 32'h0);
    start(9'h030, 32'h00000400, 1'b0, 1'b0);
    chk_res(CLS_FAIL_ID, 20'h0, 32'h0, 32'h0);
    // no result requested: carry and result write stay low
    @(posedge clk_sys);
    start_wc <= 1'b0;
    start(9'h030, 32'h00000400, 1'b1, 1'b0);
    chk(32'(carry), 32'h0);
    chk(32'(res_we), 32'h0);
    chk(res_val, CLS_FAIL_ID);
    @(posedge clk_sys);
    start_wc <= 1'b1;
    reg_op(1'b0, CLS_REG_LAST, 32'h1F);
    reg_op(1'b1, CLS_REG_MASK, 32'hFF);
    // load and run, prompt then slow memory, second is a restart
    for (int k = 0; k < 2; k++) begin
      lat   <= k ? 4'h4 : 4'h1;
      cbase = 20'h01000 + 20'(k * 256);
      loc_n = 0;
      start(9'h007, {12'h000, cbase}, 1'b1, 1'b0);
      chk(32'(run_c1[7]), 32'h0);
      chk(32'(busy), 32'h0);
      chk(32'(loc_n), 32'h1F8);
      chk(32'(last_a), 32'(CLS_COPY_LAST));
      chk_res(32'h7, CLS_LOC_START, {12'h000, cbase}, 32'h0);
    end
    // frozen clock enable: a stop is ignored
    @(posedge clk_sys);
    ce        <= 1'b0;
    stop_req  <= 1'b1;
    stop_dest <= 9'h007;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    @(negedge clk_sys);
    chk(32'(core_halt), 32'h0);
    chk(32'(running[7]), 32'h1);
    // second reset in mid-run
    @(posedge clk_sys);
    ce  <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(32'(running), 32'h0);
    reg_op(1'b0, CLS_REG_MASK, 32'hFF);
    stop_test;
  end
endmodule : test_core_launch_stop_control
